// [src/fss_pkg.sv]
package fss_pkg;

    // Step selection and hold delay widths
    localparam int        STEP_W         = 5;
    localparam int        HOLD_W         = 16;
    localparam logic [4:0] STEP_FIRST    = 5'h01;
    localparam logic [4:0] STEP_LAST     = 5'h1B;

    // Status codes on the five status outputs
    localparam logic [4:0] CODE_ALARM    = 5'h00;
    localparam logic [4:0] CODE_READY    = 5'h01;
    localparam logic [4:0] CODE_HOMING   = 5'h02;
    localparam logic [4:0] CODE_HOMED    = 5'h03;
    localparam logic [4:0] CODE_MOVING   = 5'h04;
    localparam logic [4:0] CODE_POS_BASE = 5'h04;

    // Timing: hold delay unit and clock rate
    localparam int        CLK_HZ         = 40_000_000;
    localparam int        HOLD_UNIT_MS   = 4;
    localparam int        HOLD_UNIT_CYC  = CLK_HZ / 1000 * HOLD_UNIT_MS;
    localparam int        HOLD_PER_SEC   = 125;

    // Register map of the controller end (byte addresses)
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STAT     = 12'h004;
    localparam logic [11:0] OFS_HOLD     = 12'h008;
    localparam logic [11:0] OFS_TMIN     = 12'h00C;

    // Control register fields
    localparam int        CTRL_STEP_LSB  = 0;
    localparam int        CTRL_MZ_BIT    = 5;
    localparam int        CTRL_MO_BIT    = 6;
    localparam int        CTRL_SS_BIT    = 7;
    localparam int        CTRL_VAR_BIT   = 8;
    localparam logic [8:0] CTRL_RST      = 9'h000;

    // Status register fields, hold and tmin reset values
    localparam int        STAT_REHOME_BIT = 5;
    localparam logic [15:0] HOLD_RST     = 16'h0000;
    localparam logic [15:0] TMIN_RST     = 16'h0001;

    // Drive state decoded from the two mode inputs
    typedef enum logic [1:0] {
        FSS_TORQUE_DEC,
        FSS_FEED_STEP,
        FSS_HOMING,
        FSS_ESTOP
    } fss_state_t;

    // In-position code for a given feed step
    function automatic logic [4:0] fss_pos_code(input logic [4:0] step);
        return 5'(step + CODE_POS_BASE);
    endfunction

endpackage

// [src/fss_link_if.sv]
`timescale 1ns/1ps
interface fss_link_if;
    logic [4:0]  step_sel;
    logic        mode_in_zero;
    logic        mode_in_one;
    logic        single_step_mode_sel;
    logic        manual_variant_two;
    logic [15:0] completion_hold_delay;
    logic [4:0]  status_out;

    // Drive end: reads discrete inputs, drives status outputs
    modport dev (
        input  step_sel,
        input  mode_in_zero,
        input  mode_in_one,
        input  single_step_mode_sel,
        input  manual_variant_two,
        input  completion_hold_delay,
        output status_out
    );

    // Controller end: drives discrete inputs, reads status
    modport ctl (
        output step_sel,
        output mode_in_zero,
        output mode_in_one,
        output single_step_mode_sel,
        output manual_variant_two,
        output completion_hold_delay,
        input  status_out
    );
endinterface

// [src/fss_drive_end.sv]
`timescale 1ns/1ps
module fss_drive_end #(
    parameter int HOLD_UNIT_CYCLES = fss_pkg::HOLD_UNIT_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    fss_link_if.dev                lnk,
    input  wire logic              alarm,
    input  wire logic              servo_ready,
    input  wire logic              homing_busy,
    input  wire logic              homing_done,
    input  wire logic              move_busy,
    input  wire logic              move_done,
    output logic [4:0]             target_step,
    output logic                   move_start,
    output logic                   move_fwd,
    output logic                   speed_second,
    output fss_pkg::fss_state_t    drive_state,
    output logic                   manual_active
);
    import fss_pkg::*;

    localparam int PRE_W = $clog2(HOLD_UNIT_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(HOLD_UNIT_CYCLES - 1);

    logic [8:0]       sync1_r;
    logic [8:0]       sync2_r;
    logic [8:0]       prev_r;
    logic [4:0]       cur_step_r;
    logic [4:0]       cur_step_nxt;
    logic [4:0]       target_step_r;
    logic             move_start_r;
    logic             move_fwd_r;
    logic             speed_second_r;
    fss_state_t       drive_state_r;
    fss_state_t       drive_state_nxt;
    logic             manual_r;
    logic             home_done_r;
    logic             inpos_r;
    logic [4:0]       inpos_step_r;
    logic [15:0]      hold_units_r;
    logic [PRE_W-1:0] hold_pre_r;
    logic [4:0]       status_r;
    logic [4:0]       status_nxt;

    // Two-stage synchroniser on every discrete input except completion_hold_delay, which is read directly
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
            prev_r  <= 9'h000;
        end else begin
            sync1_r <= {lnk.manual_variant_two, lnk.single_step_mode_sel,
                        lnk.mode_in_one, lnk.mode_in_zero,
                        lnk.step_sel};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Decoded synchronised inputs and edges
    wire [4:0] step_v    = sync2_r[4:0];
    wire       mz        = sync2_r[5];
    wire       mo        = sync2_r[6];
    wire       ss        = sync2_r[7];
    wire       var_two   = sync2_r[8];
    wire       rise_mz   = mz & ~prev_r[5];
    wire       rise_mo   = mo & ~prev_r[6];
    wire       step_chg  = step_v != prev_r[4:0];
    wire       can_move  = ~alarm & ~move_busy & ~move_start_r;
    wire [4:0] sel_step  = 5'(step_v + STEP_FIRST);
    wire       sel_ok    = step_v < STEP_LAST;
    wire       man_fwd   = ss & (var_two ? rise_mz : rise_mo);
    wire       man_rev   = ss & (var_two ? rise_mo : rise_mz);
    wire       feed_go   = ~ss & (drive_state_nxt == FSS_FEED_STEP) &
                           (drive_state_r != FSS_FEED_STEP) & sel_ok;
    wire       do_fwd    = man_fwd & ~man_rev & can_move;
    wire       do_rev    = man_rev & ~man_fwd & can_move;
    wire       do_feed   = feed_go & can_move;
    wire       any_go    = do_fwd | do_rev | do_feed;
    wire [4:0] step_up   = (cur_step_r >= STEP_LAST) ? STEP_FIRST :
                           5'(cur_step_r + 5'h01);
    wire [4:0] step_down = (cur_step_r <= STEP_FIRST) ? STEP_LAST :
                           5'(cur_step_r - 5'h01);
    wire       hold_on   = hold_units_r != 16'h0000;

    // Drive state from mode inputs while not in manual mode
    always_comb begin
        drive_state_nxt = drive_state_r;
        if (!ss) begin
            unique case ({mo, mz})
                2'b00: drive_state_nxt = FSS_TORQUE_DEC;
                2'b01: drive_state_nxt = FSS_FEED_STEP;
                2'b10: drive_state_nxt = FSS_HOMING;
                2'b11: drive_state_nxt = FSS_ESTOP;
            endcase
        end
    end

    // Current step: falls back to step one on selection change in manual mode
    always_comb begin
        cur_step_nxt = cur_step_r;
        if (ss && step_chg) begin
            cur_step_nxt = STEP_FIRST;
        end else if (do_feed) begin
            cur_step_nxt = sel_step;
        end else if (do_fwd) begin
            cur_step_nxt = step_up;
        end else if (do_rev) begin
            cur_step_nxt = step_down;
        end
    end

    // Status code with fixed priority, alarm first
    always_comb begin
        if (alarm) begin
            status_nxt = CODE_ALARM;
        end else if (homing_busy) begin
            status_nxt = CODE_HOMING;
        end else if (inpos_r && hold_on) begin
            status_nxt = fss_pos_code(inpos_step_r);
        end else if (move_busy || move_start_r) begin
            status_nxt = CODE_MOVING;
        end else if (inpos_r) begin
            status_nxt = fss_pos_code(inpos_step_r);
        end else if (home_done_r) begin
            status_nxt = CODE_HOMED;
        end else if (servo_ready) begin
            status_nxt = CODE_READY;
        end else begin
            status_nxt = CODE_ALARM;
        end
    end

    // Move command issue and manual mode tracking
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_step_r     <= STEP_FIRST;
            target_step_r  <= STEP_FIRST;
            move_start_r   <= 1'b0;
            move_fwd_r     <= 1'b1;
            speed_second_r <= 1'b0;
            drive_state_r  <= FSS_TORQUE_DEC;
            manual_r       <= 1'b0;
        end else begin
            cur_step_r    <= cur_step_nxt;
            move_start_r  <= any_go;
            drive_state_r <= drive_state_nxt;
            manual_r      <= ss;
            if (any_go) begin
                target_step_r  <= cur_step_nxt;
                move_fwd_r     <= ~do_rev;
                speed_second_r <= ss & var_two;
            end
        end
    end

    // Homed flag, in-position latch and 4 ms hold counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            home_done_r  <= 1'b0;
            inpos_r      <= 1'b0;
            inpos_step_r <= STEP_FIRST;
            hold_units_r <= 16'h0000;
            hold_pre_r   <= '0;
        end else begin
            if (homing_done) begin
                home_done_r <= 1'b1;
            end else if (alarm || move_start_r) begin
                home_done_r <= 1'b0;
            end
            if (move_done) begin
                inpos_r      <= 1'b1;
                inpos_step_r <= target_step_r;
                hold_units_r <= lnk.completion_hold_delay;
                hold_pre_r   <= '0;
            end else begin
                if (alarm || move_start_r || homing_busy) begin
                    inpos_r <= 1'b0;
                end
                if (hold_on) begin
                    if (hold_pre_r == PRE_LAST) begin
                        hold_pre_r   <= '0;
                        hold_units_r <= 16'(hold_units_r - 16'h0001);
                    end else begin
                        hold_pre_r <= PRE_W'(hold_pre_r + 1'b1);
                    end
                end
            end
        end
    end

    // All five status bits leave one register together
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_r <= CODE_ALARM;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign lnk.status_out = status_r;
    assign target_step    = target_step_r;
    assign move_start     = move_start_r;
    assign move_fwd       = move_fwd_r;
    assign speed_second   = speed_second_r;
    assign drive_state    = drive_state_r;
    assign manual_active  = manual_r;
endmodule

// [src/fss_ctl_end.sv]
`timescale 1ns/1ps
module fss_ctl_end (
    input  wire logic          mclk,
    input  wire logic          rst,
    fss_link_if.ctl            lnk,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr
);
    import fss_pkg::*;

    logic [8:0]  ctrl_r;
    logic [15:0] hold_r;
    logic [15:0] tmin_r;
    logic        rehome_r;
    logic [4:0]  st1_r;
    logic [4:0]  st2_r;
    logic [4:0]  st_prev_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [4:0]  step_o_r;
    logic        mz_o_r;
    logic        mo_o_r;
    logic        ss_o_r;
    logic        var_o_r;
    logic [15:0] hold_o_r;

    // Address decode and bus phases
    wire        setup    = psel & ~penable;
    wire        wr_done  = psel & penable & pready_r & pwrite;
    wire        hit_ctrl = paddr == OFS_CTRL;
    wire        hit_stat = paddr == OFS_STAT;
    wire        hit_hold = paddr == OFS_HOLD;
    wire        hit_tmin = paddr == OFS_TMIN;
    wire        mapped   = hit_ctrl | hit_stat | hit_hold | hit_tmin;
    wire [31:0] rd_mux   = hit_ctrl ? {23'h0, ctrl_r} :
                           hit_stat ? {26'h0, rehome_r, st2_r} :
                           hit_hold ? {16'h0, hold_r} :
                           hit_tmin ? {16'h0, tmin_r} : 32'h0;

    // Requested outputs and the hold delay ceiling
    wire [4:0]  req_step = ctrl_r[CTRL_STEP_LSB +: 5];
    wire        req_mz   = ctrl_r[CTRL_MZ_BIT];
    wire        req_mo   = ctrl_r[CTRL_MO_BIT];
    wire        req_ss   = ctrl_r[CTRL_SS_BIT];
    wire        req_var  = ctrl_r[CTRL_VAR_BIT];
    wire [23:0] hold_cap = 24'(tmin_r) * 24'(HOLD_PER_SEC);
    wire [15:0] hold_lim = (24'(hold_r) > hold_cap) ? hold_cap[15:0] :
                           hold_r;
    wire        leaving  = ss_o_r & ~req_ss;
    wire        modes_on = mz_o_r | mo_o_r;
    wire        homing_w = wr_done & hit_ctrl &
                           (pwdata[CTRL_MO_BIT] & ~pwdata[CTRL_MZ_BIT]);
    wire        fault_rt = (st_prev_r == CODE_HOMING) &
                           (st2_r == CODE_READY);

    // APB slave: zero wait states, unmapped address errors
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // Software registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            hold_r <= HOLD_RST;
            tmin_r <= TMIN_RST;
        end else if (wr_done) begin
            if (hit_ctrl) begin
                ctrl_r <= pwdata[8:0];
            end
            if (hit_hold) begin
                hold_r <= pwdata[15:0];
            end
            if (hit_tmin) begin
                tmin_r <= pwdata[15:0];
            end
        end
    end

    // Status sync and lost-home flag; a new fault beats the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            st1_r     <= CODE_ALARM;
            st2_r     <= CODE_ALARM;
            st_prev_r <= CODE_ALARM;
            rehome_r  <= 1'b0;
        end else begin
            st1_r     <= lnk.status_out;
            st2_r     <= st1_r;
            st_prev_r <= st2_r;
            if (fault_rt) begin
                rehome_r <= 1'b1;
            end else if (homing_w) begin
                rehome_r <= 1'b0;
            end
        end
    end

    // Sequenced drive of the discrete inputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            step_o_r <= 5'h00;
            mz_o_r   <= 1'b0;
            mo_o_r   <= 1'b0;
            ss_o_r   <= 1'b0;
            var_o_r  <= 1'b0;
            hold_o_r <= HOLD_RST;
        end else begin
            hold_o_r <= hold_lim;
            if (!ss_o_r) begin
                step_o_r <= req_step;
                var_o_r  <= req_var;
            end
            if (leaving) begin
                mz_o_r <= 1'b0;
                mo_o_r <= 1'b0;
                ss_o_r <= modes_on;
            end else begin
                ss_o_r <= req_ss;
                mo_o_r <= req_mo;
                if (req_ss && !req_var && req_mo && !mo_o_r) begin
                    mz_o_r <= 1'b0;
                end else begin
                    mz_o_r <= req_mz;
                end
            end
        end
    end

    assign prdata                    = prdata_r;
    assign pready                    = pready_r;
    assign pslverr                   = pslverr_r;
    assign lnk.step_sel              = step_o_r;
    assign lnk.mode_in_zero          = mz_o_r;
    assign lnk.mode_in_one           = mo_o_r;
    assign lnk.single_step_mode_sel  = ss_o_r;
    assign lnk.manual_variant_two    = var_o_r;
    assign lnk.completion_hold_delay = hold_o_r;
endmodule

// [bench/fss_link_assertions.sv]
`timescale 1ns/1ps
module fss_link_assertions (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [4:0] step_sel,
    input wire logic       mode_in_zero,
    input wire logic       mode_in_one,
    input wire logic       single_step_mode_sel,
    input wire logic       manual_variant_two,
    input wire logic [4:0] status_out,
    input wire logic       alarm,
    input wire logic       homing_busy,
    input wire logic       move_busy,
    input wire logic       move_start,
    input wire logic [4:0] target_step,
    input wire logic       move_fwd,
    input wire logic       speed_second,
    input wire logic       manual_active
);
    import fss_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Manual step pulses by direction
    sequence fwd_step_s;
        move_start && move_fwd;
    endsequence
    sequence rev_step_s;
        move_start && !move_fwd;
    endsequence

    alarm_code_a: assert property (
        alarm |=> status_out == CODE_ALARM)
        else $error("status not zero under alarm");
    homing_code_a: assert property (
        homing_busy && !alarm |=> status_out == CODE_HOMING)
        else $error("status not two while homing");
    moving_code_a: assert property (
        move_start && !alarm && !homing_busy |-> ##[1:2]
        status_out == CODE_MOVING)
        else $error("status not four after move start");
    feed_target_a: assert property (
        move_start && !manual_active |-> target_step == 5'(step_sel + 5'h01))
        else $error("feed target not selection plus one");
    step_fwd_a: assert property (
        single_step_mode_sel && manual_variant_two && $rose(mode_in_zero)
        && !mode_in_one && !move_busy |-> ##[2:4] fwd_step_s)
        else $error("no forward step on zero input rise");
    step_rev_a: assert property (
        single_step_mode_sel && manual_variant_two && $rose(mode_in_one)
        && !mode_in_zero && !move_busy |-> ##[2:4] rev_step_s)
        else $error("no reverse step on one input rise");
    manual_speed_a: assert property (
        move_start && manual_active |-> speed_second == manual_variant_two)
        else $error("manual speed selection wrong");
    leave_order_a: assert property (
        $fell(single_step_mode_sel) |->
        !$past(mode_in_zero) && !$past(mode_in_one))
        else $error("select dropped with mode inputs high");
    step_frozen_a: assert property (
        single_step_mode_sel && $past(single_step_mode_sel) |->
        $stable(step_sel))
        else $error("step selection changed in manual mode");
    one_first_a: assert property (
        single_step_mode_sel && !manual_variant_two && $rose(mode_in_zero)
        |-> !mode_in_one || $past(mode_in_one))
        else $error("zero input rose with one input");
endmodule

// [bench/feed_step_io_sequencer_bench.sv]
`timescale 1ns/1ps
module feed_step_io_sequencer_bench;
    import fss_pkg::*;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        alarm = 1'b0;
    logic        servo_ready = 1'b0;
    logic        homing_busy = 1'b0;
    logic        homing_done = 1'b0;
    logic        move_busy = 1'b0;
    logic        move_done = 1'b0;
    logic [4:0]  target_step;
    logic        move_start;
    logic        move_fwd;
    logic        speed_second;
    logic        manual_active;
    fss_state_t  drive_state;
    int          failures = 0;
    int          total_checks = 0;
    logic [33:0] aq[$];
    logic [7:0]  mq[$];
    logic [33:0] ea;
    logic [7:0]  em;
    int          i;

    always #12.5 mclk = ~mclk;

    fss_link_if u_fss_link_if ();

    fss_drive_end #(.HOLD_UNIT_CYCLES(4)) u_fss_drive_end (
        .mclk(mclk), .rst(rst), .lnk(u_fss_link_if), .alarm(alarm),
        .servo_ready(servo_ready), .homing_busy(homing_busy),
        .homing_done(homing_done), .move_busy(move_busy),
        .move_done(move_done), .target_step(target_step),
        .move_start(move_start), .move_fwd(move_fwd),
        .speed_second(speed_second), .drive_state(drive_state),
        .manual_active(manual_active));

    fss_ctl_end u_fss_ctl_end (
        .mclk(mclk), .rst(rst), .lnk(u_fss_link_if), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    fss_link_assertions u_fss_link_assertions (
        .mclk(mclk), .rst(rst), .step_sel(u_fss_link_if.step_sel),
        .mode_in_zero(u_fss_link_if.mode_in_zero),
        .mode_in_one(u_fss_link_if.mode_in_one),
        .single_step_mode_sel(u_fss_link_if.single_step_mode_sel),
        .manual_variant_two(u_fss_link_if.manual_variant_two),
        .status_out(u_fss_link_if.status_out), .alarm(alarm),
        .homing_busy(homing_busy), .move_busy(move_busy),
        .move_start(move_start), .target_step(target_step),
        .move_fwd(move_fwd), .speed_second(speed_second),
        .manual_active(manual_active));

    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic hang;
        failures++;
        final_report();
    endtask

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Feed moves check target only, manual ones direction and speed too
    task automatic cmp_move(input logic [7:0] e);
        logic [7:0] g;
        g = {target_step, e[2], e[2] ? {move_fwd, speed_second} : 2'b00};
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // APB transfer; expectation noted before the request goes out
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        int n;
        aq.push_back({e, err, wr});
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hang();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ctrl(input logic [8:0] c);
        apb(1'b1, OFS_CTRL, {23'h0, c}, 32'h0, 1'b0);
    endtask

    task automatic stat(input logic [5:0] e);
        repeat (6) @(posedge mclk);
        apb(1'b0, OFS_STAT, 32'h0, {26'h0, e}, 1'b0);
    endtask

    task automatic wait_moves;
        int n;
        n = 0;
        while (mq.size() != 0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (mq.size() != 0) hang();
        repeat (6) @(posedge mclk);
    endtask

    // One feed move: busy, done, then in-position code
    task automatic feed(input logic [4:0] s);
        if (s <= 5'h1A) mq.push_back({5'(s + 5'h01), 3'b000});
        ctrl(9'h020 | 9'(s));
        wait_moves();
        cmp_word({30'h0, drive_state}, {30'h0, FSS_FEED_STEP});
        if (s <= 5'h1A) begin
            move_busy <= 1'b1;
            stat({1'b0, CODE_MOVING});
            move_busy <= 1'b0;
            move_done <= 1'b1;
            @(posedge mclk);
            move_done <= 1'b0;
            stat({1'b0, 5'(s + 5'h05)});
        end
        ctrl(9'h000);
        repeat (6) @(posedge mclk);
    endtask

    // Result watcher: oldest note against what appears
    always @(posedge mclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            ea = aq.pop_front();
            cmp_word({31'h0, pslverr}, {31'h0, ea[1]});
            if (!ea[0]) cmp_word(prdata, ea[33:2]);
        end
        if (move_start === 1'b1) begin
            em = (mq.size() != 0) ? mq.pop_front() : 8'h00;
            cmp_move(em);
        end
    end

    initial begin
        #(25 * 80000);
        hang();
    end

    initial begin
        void'($urandom(32'hB86AA871));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, OFS_STAT, 32'h0, 32'h0, 1'b0);
        apb(1'b0, OFS_HOLD, 32'h0, 32'h0, 1'b0);
        apb(1'b0, OFS_TMIN, 32'h0, 32'h1, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h5, 32'h0, 1'b1);
        servo_ready <= 1'b1;
        stat({1'b0, CODE_READY});
        alarm       <= 1'b1;
        homing_busy <= 1'b1;
        stat({1'b0, CODE_ALARM});
        alarm <= 1'b0;
        stat({1'b0, CODE_HOMING});
        homing_busy <= 1'b0;
        stat({1'b1, CODE_READY});
        ctrl(9'h040);
        stat({1'b0, CODE_READY});
        cmp_word({30'h0, drive_state}, {30'h0, FSS_HOMING});
        ctrl(9'h060);
        repeat (6) @(posedge mclk);
        cmp_word({30'h0, drive_state}, {30'h0, FSS_ESTOP});
        ctrl(9'h000);
        homing_busy <= 1'b1;
        @(posedge mclk);
        homing_done <= 1'b1; // Done pulse lands while still busy
        @(posedge mclk);
        homing_busy <= 1'b0;
        homing_done <= 1'b0;
        stat({1'b0, CODE_HOMED});
        apb(1'b1, OFS_HOLD, 32'h0C8, 32'h0, 1'b0);
        repeat (3) @(posedge mclk);
        cmp_word({16'h0, u_fss_link_if.completion_hold_delay}, 32'h7D);
        apb(1'b1, OFS_HOLD, 32'h3, 32'h0, 1'b0);
        repeat (3) @(posedge mclk);
        cmp_word({16'h0, u_fss_link_if.completion_hold_delay}, 32'h3);
        for (i = 0; i < 3; i++) begin
            feed(5'($urandom_range(25, 1)));
        end
        feed(5'h00);
        feed(5'h1B);
        feed(5'h1A);
        ctrl(9'h01A);
        ctrl(9'h19A);
        mq.push_back({5'h01, 3'b111});
        ctrl(9'h1BA);
        wait_moves();
        cmp_word({31'h0, manual_active}, 32'h1);
        ctrl(9'h19A);
        mq.push_back({5'h1B, 3'b101});
        ctrl(9'h1DA);
        wait_moves();
        ctrl(9'h01A);
        ctrl(9'h09A);
        mq.push_back({5'h01, 3'b110});
        ctrl(9'h0DA);
        wait_moves();
        ctrl(9'h09A);
        mq.push_back({5'h1B, 3'b100});
        ctrl(9'h0BA);
        wait_moves();
        ctrl(9'h09A);
        mq.push_back({5'h01, 3'b110});
        ctrl(9'h0FA);
        wait_moves();
        ctrl(9'h0A3);
        ctrl(9'h000);
        repeat (8) @(posedge mclk);
        cmp_word({31'h0, manual_active}, 32'h0);
        cmp_word({30'h0, drive_state}, {30'h0, FSS_TORQUE_DEC});
        final_report();
    end
endmodule
